// *** logic/osc_switch_pkg.sv ***
// Purpose: Constants and carriers for the oscillator clock switch block
// Assumes: core_clk at 250 MHz, AXI4-Lite register access with 32-bit data
// Notes: Source clocks are modelled as levels sampled on core_clk
// How it works
// - Eight-bit trim, larger value means longer period
// - Reset loads trim midpoint, oscillator restarts there
// - External select makes input pin a clock
// - Two external rising edges confirm activity
// - Changeover is glitch free on clock outputs
// - Engaged flag set before internal oscillator stops
// - Only reset restarts internal oscillator, no fallback
// - External clock drives x4, halved for x2
// - External option: output pin is port I/O
// - Crystal option: output pin is amplifier output
// - Internal/RC: enable bit picks port or x4
// - Integration unit enable gates selected oscillator
// - clock_x4 equals selected source clock
// - clock_x2 runs at half of clock_x4
// - Internal oscillator nominally 4.0 MHz
// - Wait mode leaves clocks running
// - Stop mode halts source and both clocks
// - Two-bit source code: internal, external, RC, crystal
// - Switch request is read/write, cleared by reset
// - Engaged flag is read-only source status
package osc_switch_pkg;

  // Register byte offsets
  localparam logic [7:0] TRIM_OFFSET = 8'h38;
  localparam logic [7:0] STATUS_OFFSET = 8'h3C;
  localparam logic [7:0] CONFIG_OFFSET = 8'h40;

  // Field positions
  localparam int REQ_BIT = 0;
  localparam int ENGAGED_BIT = 1;
  localparam int SEL_LSB = 0;
  localparam int OUTEN_BIT = 2;

  // Values after reset
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [1:0] SEL_RESET = 2'h0;

  // Internal oscillator timing, period counted in eighths of a core cycle
  localparam int CORE_MHZ = 250;
  localparam int INT_OSC_MHZ = 4;
  localparam logic [9:0] PERIOD_EIGHTHS = 10'(8 * CORE_MHZ / INT_OSC_MHZ);
  localparam logic [9:0] STEP_SIXTEENTHS = 10'h010;
  localparam logic [1:0] CONFIRM_EDGES = 2'h2;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_EXTERNAL = 2'h1,
    SRC_RC = 2'h2,
    SRC_CRYSTAL = 2'h3
  } source_e;

  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_CONFIRM = 2'h1,
    SW_ALIGN = 2'h3,
    SW_DONE = 2'h2
  } switch_e;

  // Derived clocks toward the integration unit
  typedef struct packed {
    logic x4;
    logic x2;
  } clocks_s;

  // Pin steering toward the pad logic
  typedef struct packed {
    logic inIsClock;
    logic outO;
    logic outOe;
  } pins_s;

endpackage

// *** logic/oscillator_clock_switch.sv ***
// Purpose: Clock source selection, trimmed internal oscillator and switch to external clock
// Assumes: Source clocks far slower than core_clk; AXI master holds payloads until taken
// Notes: All derived clocks are levels built in the core_clk domain
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module oscillator_clock_switch
  import osc_switch_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clockInPin,
  input wire logic portA4Out,
  input wire logic portA4Oe,
  input wire logic oscEnableFromSysint,
  input wire logic stopMode,
  output clocks_s clocks,
  output pins_s pins,
  output logic [7:0] trimValue
);

  // Bus state
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;

  // Block state
  logic [7:0] trim_r;
  logic [7:0] trimAct_r;
  logic req_r;
  logic engaged_r;
  logic intRun_r;
  logic [1:0] sel_r;
  logic outEn_r;
  switch_e state_r;
  switch_e state_nxt;
  logic [1:0] edgeCnt_r;
  logic [9:0] acc_r;
  logic internal_osc_clock_r;
  logic extS1_r;
  logic extS2_r;
  logic extPrev_r;
  logic x4_r;
  logic x2_r;
  logic outO_r;
  logic outOe_r;

  // Address decode, one function for both channels
  function automatic logic [1:0] decode(input logic [7:0] addr);
    if (addr == TRIM_OFFSET) begin
      decode = 2'h1;
    end else if (addr == STATUS_OFFSET) begin
      decode = 2'h2;
    end else if (addr == CONFIG_OFFSET) begin
      decode = 2'h3;
    end else begin
      decode = 2'h0;
    end
  endfunction

  // Write channel handshakes and commit
  wire [1:0] wrSel = decode(awAddr_r);
  wire doWrite = awHeld_r && wHeld_r && !bValid_r;
  wire lowLane = wStrb_r[0];
  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  // Read channel handshakes
  wire [1:0] rdSel = decode(s_axi_araddr);
  wire doRead = s_axi_arvalid && !rValid_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // Read mux, unused bits read zero
  wire [31:0] rdWord =
    (rdSel == 2'h1) ? {24'h000000, trim_r} :
    (rdSel == 2'h2) ? {30'h00000000, engaged_r, req_r} :
    (rdSel == 2'h3) ? {29'h00000000, outEn_r, sel_r} :
    32'h00000000;

  // Write side: capture each channel, commit once both are held
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r <= (wrSel == 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // Read answer stands until rready; arready stays low meanwhile
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= RESP_OKAY;
    end else if (doRead) begin
      rValid_r <= 1'b1;
      rData_r <= rdWord;
      rResp_r <= (rdSel == 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // Software registers; trim and request start from defined values
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trim_r <= TRIM_RESET;
      req_r <= 1'b0;
      sel_r <= SEL_RESET;
      outEn_r <= 1'b0;
    end else if (doWrite && lowLane) begin
      if (wrSel == 2'h1) begin
        trim_r <= wData_r[7:0];
      end
      if (wrSel == 2'h2) begin
        req_r <= wData_r[REQ_BIT];
      end
      if (wrSel == 2'h3) begin
        sel_r <= wData_r[SEL_LSB +: 2];
        outEn_r <= wData_r[OUTEN_BIT];
      end
    end
  end

  // Selected source runs only while enabled and not stopped; wait mode has no input here
  wire srcRun = oscEnableFromSysint && !stopMode;
  wire selExt = (sel_r != SRC_INTERNAL);

  // Pin into clock domain through two flops, nothing reads the first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      extS1_r <= 1'b0;
      extS2_r <= 1'b0;
      extPrev_r <= 1'b0;
    end else begin
      extS1_r <= clockInPin;
      extS2_r <= extS1_r;
      extPrev_r <= extS2_r;
    end
  end
  wire extRise = extS2_r && !extPrev_r;
  wire extFall = !extS2_r && extPrev_r;

  // Internal oscillator: half period in sixteenths equals full period in eighths
  wire [9:0] periodEighths = PERIOD_EIGHTHS - 10'(TRIM_RESET) + 10'(trimAct_r);
  wire [9:0] accSum = acc_r + STEP_SIXTEENTHS;
  wire halfDone = (accSum >= periodEighths);
  wire intAdvance = intRun_r && srcRun;

  // Trim is applied at half-period boundaries only,
  // so a trim write never cuts the running phase short
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_r <= 10'h000;
      internal_osc_clock_r <= 1'b0;
      trimAct_r <= TRIM_RESET;
    end else if (intAdvance) begin
      acc_r <= halfDone ? (accSum - periodEighths) : accSum;
      internal_osc_clock_r <= halfDone ? !internal_osc_clock_r : internal_osc_clock_r;
      trimAct_r <= halfDone ? trim_r : trimAct_r;
    end
  end

  // Changeover sequencer
  // Hand over at an external fall while internal is low: the external low phase is whole
  wire bothLow = !internal_osc_clock_r && extFall;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SW_IDLE: begin
        if (req_r && selExt) begin
          state_nxt = SW_CONFIRM;
        end
      end
      SW_CONFIRM: begin
        if (!req_r) begin
          state_nxt = SW_IDLE;
        end else if (extRise && edgeCnt_r == CONFIRM_EDGES - 2'h1) begin
          state_nxt = SW_ALIGN;
        end
      end
      SW_ALIGN: begin
        if (!req_r) begin
          state_nxt = SW_IDLE;
        end else if (bothLow) begin
          state_nxt = SW_DONE;
        end
      end
      SW_DONE: begin
        state_nxt = SW_DONE;
      end
      default: begin
        state_nxt = SW_IDLE;
      end
    endcase
  end

  // Engaged rises on entry to done; oscillator stops one cycle later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= SW_IDLE;
      edgeCnt_r <= 2'h0;
      engaged_r <= 1'b0;
      intRun_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      edgeCnt_r <= (state_r != SW_CONFIRM) ? 2'h0 : (extRise ? edgeCnt_r + 2'h1 : edgeCnt_r);
      if (state_nxt == SW_DONE) begin
        engaged_r <= 1'b1;
      end
      if (engaged_r) begin
        intRun_r <= 1'b0;
      end
    end
  end

  // Derived clocks; a halted source freezes both levels so no runt pulse appears
  wire srcLevel = engaged_r ? extS2_r : internal_osc_clock_r;
  wire x4Nxt = srcRun ? srcLevel : x4_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      x4_r <= 1'b0;
      x2_r <= 1'b0;
    end else begin
      x4_r <= x4Nxt;
      x2_r <= (x4Nxt && !x4_r) ? !x2_r : x2_r;
    end
  end
  assign clocks.x4 = x4_r;
  assign clocks.x2 = x2_r;

  // Output pin steering by source option
  wire srcXtal = (sel_r == SRC_CRYSTAL);
  wire srcPlain = (sel_r == SRC_EXTERNAL);
  wire driveX4 = !srcXtal && !srcPlain && outEn_r;
  wire outONxt = srcXtal ? !extS2_r : (driveX4 ? x4Nxt : portA4Out);
  wire outOeNxt = srcXtal || driveX4 || portA4Oe;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outO_r <= 1'b0;
      outOe_r <= 1'b0;
    end else begin
      outO_r <= outONxt;
      outOe_r <= outOeNxt;
    end
  end
  // Pin function and trim mirror go straight out
  assign pins.inIsClock = selExt;
  assign pins.outO = outO_r;
  assign pins.outOe = outOe_r;
  assign trimValue = trim_r;

endmodule // oscillator_clock_switch

// *** verif/osc_switch_sva.sv ***
// Purpose: Port assertions for the oscillator clock switch
// Assumes: External clock half period of five core cycles or more
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
module osc_switch_sva
  import osc_switch_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stopMode,
  input wire logic oscEnableFromSysint,
  input wire clocks_s clocks,
  input wire logic [7:0] trimValue
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Pulse widths and freeze windows
  sequence highHold;
    clocks.x4 [*3];
  endsequence
  sequence lowHold;
    !clocks.x4 [*3];
  endsequence
  sequence twoStop;
    stopMode ##1 stopMode;
  endsequence
  sequence twoOff;
    !oscEnableFromSysint ##1 !oscEnableFromSysint;
  endsequence
  trim_reset_a: assert property ($fell(rst) |-> trimValue == TRIM_RESET)
    else $error("trim not at midpoint after reset");
  clock_idle_a: assert property ($fell(rst) |-> !clocks.x4 && !clocks.x2)
    else $error("clocks not idle after reset");
  x2_follow_a: assert property ($changed(clocks.x2) |-> $rose(clocks.x4))
    else $error("x2 moved without x4 rise");
  high_pulse_a: assert property ($rose(clocks.x4) |=> highHold)
    else $error("short high pulse on x4");
  low_pulse_a: assert property ($fell(clocks.x4) |=> lowHold)
    else $error("short low pulse on x4");
  stop_freeze_a: assert property (twoStop |=> $stable(clocks))
    else $error("clocks ran in stop mode");
  enable_freeze_a: assert property (twoOff |=> $stable(clocks))
    else $error("clocks ran while disabled");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
endmodule // osc_switch_sva

// *** verif/siu_clock_model.sv ***
// Purpose: External clock source and integration unit clock counters
// Assumes: Source stands low while not running
// Notes: Half period 25 ns, unrelated to core_clk
`timescale 1ns/1ps
module siu_clock_model
  import osc_switch_pkg::*;
(
  input wire logic extRun,
  input wire clocks_s clocks,
  output logic clockInPin,
  output int x4Rises,
  output int x2Rises
);
  // Clean from its first edge, so already stable when requested
  initial begin
    clockInPin = 1'b0;
    forever begin
      #25;
      clockInPin = extRun && !clockInPin;
    end
  end
  // Rises as the integration unit sees them
  always @(posedge clocks.x4) x4Rises <= x4Rises + 1;
  always @(posedge clocks.x2) x2Rises <= x2Rises + 1;
endmodule // siu_clock_model

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the oscillator clock switch
// Assumes: Register model in mdl, index 3 is unmapped
// Notes: Periods measured over eight x4 periods in core cycles
`timescale 1ns/1ps
module tb;
  import osc_switch_pkg::*;
  logic core_clk, rst, awValid, wValid, bReady, arValid, rReady;
  logic awReady, wReady, bValid, arReady, rValid, clockInPin, extRun;
  logic portA4Out, portA4Oe, oscEn, stopMode;
  logic [7:0] awAddr, arAddr, trimValue;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  logic [31:0] mdl [4];
  clocks_s clocks;
  pins_s pins;
  int x4Rises, x2Rises, error_cnt, cmp_count;
  oscillator_clock_switch oscillator_clock_switch_inst (.core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .clockInPin(clockInPin), .portA4Out(portA4Out), .portA4Oe(portA4Oe),
    .oscEnableFromSysint(oscEn), .stopMode(stopMode), .clocks(clocks), .pins(pins), .trimValue(trimValue));
  siu_clock_model siu_clock_model_inst (.extRun(extRun), .clocks(clocks), .clockInPin(clockInPin),
    .x4Rises(x4Rises), .x2Rises(x2Rises));
  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic int idx(input logic [7:0] a);
    return (a == TRIM_OFFSET) ? 0 : (a == STATUS_OFFSET) ? 1 : (a == CONFIG_OFFSET) ? 2 : 3;
  endfunction
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s: %h vs %h", $time, m, got, exp);
    end
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("CHECK FAILED %0t %s wait ran out", $time, m);
    close_out();
  endtask
  // Master holds each channel until its ready edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic tA, tW, tB;
    logic [1:0] r;
    @(posedge core_clk);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge core_clk);
      tA = awValid && awReady;
      tW = wValid && wReady;
      tB = bValid;
      r = bResp;
      @(posedge core_clk);
      if (tA) awValid <= 1'b0;
      if (tW) wValid <= 1'b0;
      if (tB) break;
    end
    bReady <= 1'b0;
    if (n == 64) fail("write");
    chk(32'(r), 32'(idx(a) == 3 ? RESP_SLVERR : RESP_OKAY), "bresp");
    if (s[0] && idx(a) == 0) mdl[0] = 32'(d[7:0]);
    if (s[0] && idx(a) == 1) mdl[1][REQ_BIT] = d[REQ_BIT];
    if (s[0] && idx(a) == 2) mdl[2] = 32'(d[2:0]);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic tA, tR;
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge core_clk);
      tA = arValid && arReady;
      tR = rValid;
      d = rData;
      r = rResp;
      @(posedge core_clk);
      if (tA) arValid <= 1'b0;
      if (tR) break;
    end
    rReady <= 1'b0;
    if (n == 64) fail("read");
  endtask
  task automatic chkRd(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, mdl[idx(a)], "rdata");
    chk(32'(r), 32'(idx(a) == 3 ? RESP_SLVERR : RESP_OKAY), "rresp");
  endtask
  // Eight x4 periods must span exp cycles, with four x2 rises
  task automatic period(input int exp);
    int n, c0, c2;
    c0 = x4Rises;
    for (n = 0; n < 2000 && x4Rises == c0; n++) @(posedge core_clk);
    if (n == 2000) fail("x4 start");
    c0 = x4Rises;
    c2 = x2Rises;
    for (n = 0; n < 4000 && x4Rises < c0 + 8; n++) @(posedge core_clk);
    if (n == 4000) fail("x4 run");
    chk(32'(n > exp - 3 && n < exp + 3), 32'h1, "x4 period");
    chk(32'(x2Rises - c2), 32'h4, "x2 rises");
  endtask
  task automatic freeze(input string m);
    int c0;
    repeat (8) @(posedge core_clk);
    c0 = x4Rises;
    repeat (300) @(posedge core_clk);
    chk(32'(x4Rises - c0), 32'h0, m);
  endtask
  task automatic pinChk(input logic [2:0] cfg);
    logic p, port;
    wr(CONFIG_OFFSET, 32'(cfg), 4'hF);
    chkRd(CONFIG_OFFSET);
    portA4Out <= 1'($urandom);
    portA4Oe <= 1'($urandom);
    port = cfg[1:0] == 2'h1 || (!cfg[0] && !cfg[2]);
    repeat (4) @(negedge core_clk);
    p = cfg[0] ? !clockInPin : clocks.x4;
    chk(32'(pins.inIsClock), 32'(cfg[1:0] != 2'h0), "input pin");
    chk(32'(pins.outOe), 32'(port ? portA4Oe : 1'b1), "pin enable");
    chk(32'(pins.outO), 32'(port ? portA4Out : p), "pin data");
  endtask
  task automatic doReset();
    rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    mdl = '{32'(TRIM_RESET), 32'h0, 32'h0, 32'h0};
  endtask
  // Main sequence
  initial begin
    int n, t;
    logic [31:0] d;
    logic [1:0] r;
    {awValid, wValid, bReady, arValid, rReady, portA4Out, portA4Oe, stopMode, extRun} = '0;
    {awAddr, arAddr, wData} = '0;
    wStrb = 4'hF;
    oscEn = 1'b1;
    rst = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(34));
    doReset();
    for (n = 0; n < 4; n++) chkRd(8'(8'h38 + 4 * n));
    period(500);
    for (n = 0; n < 3; n++) begin
      t = n == 0 ? 0 : n == 1 ? 255 : int'($urandom_range(254, 1));
      wr(TRIM_OFFSET, 32'(t), 4'hF);
      chkRd(TRIM_OFFSET);
      period(372 + t);
    end
    wr(TRIM_OFFSET, 32'h55, 4'hE);
    wr(8'h44, 32'h1, 4'hF);
    for (n = 0; n < 4; n++) chkRd(8'(8'h38 + 4 * n));
    stopMode <= 1'b1;
    freeze("stop");
    stopMode <= 1'b0;
    oscEn <= 1'b0;
    freeze("disabled");
    oscEn <= 1'b1;
    for (n = 0; n < 8; n++) pinChk(3'(n));
    wr(CONFIG_OFFSET, 32'h0, 4'hF);
    portA4Out <= 1'b1;
    portA4Oe <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk(32'({pins.outO, pins.outOe}), 32'h3, "precharge");
    @(posedge core_clk);
    extRun <= 1'b1;
    wr(STATUS_OFFSET, 32'h1, 4'hF);
    repeat (300) @(posedge core_clk);
    chkRd(STATUS_OFFSET);
    extRun <= 1'b0;
    wr(STATUS_OFFSET, 32'h0, 4'hF);
    wr(CONFIG_OFFSET, 32'h1, 4'hF);
    wr(STATUS_OFFSET, 32'h1, 4'hF);
    repeat (300) @(posedge core_clk);
    chkRd(STATUS_OFFSET);
    extRun <= 1'b1;
    for (n = 0; n < 100; n++) begin
      rd(STATUS_OFFSET, d, r);
      if (d[ENGAGED_BIT] === 1'b1) break;
    end
    if (n == 100) fail("engage");
    mdl[1][ENGAGED_BIT] = 1'b1;
    chkRd(STATUS_OFFSET);
    wr(STATUS_OFFSET, 32'h0, 4'hF);
    chkRd(STATUS_OFFSET);
    period(100);
    extRun <= 1'b0;
    freeze("fallback");
    doReset();
    chkRd(TRIM_OFFSET);
    chkRd(STATUS_OFFSET);
    period(500);
    close_out();
  end
endmodule // tb
bind oscillator_clock_switch osc_switch_sva osc_switch_sva_inst (.core_clk(core_clk), .rst(rst),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .stopMode(stopMode), .oscEnableFromSysint(oscEnableFromSysint), .clocks(clocks), .trimValue(trimValue));
